// [shared/poc_pkg.sv]
package poc_pkg;

	localparam int N_OUT     = 8;
	localparam int N_PROF    = 10;
	localparam int N_SEQ     = 4;
	localparam int N_RPC     = 4;
	localparam int MAX_TERMS = 40;

	localparam int MCLK_HZ   = 20_000_000;
	localparam int TICK_MS   = 100;
	localparam int TICK_CYC  = MCLK_HZ / 1000 * TICK_MS;
	localparam int RP_MS     = 5000;
	localparam int RP_TICKS  = (RP_MS + TICK_MS - 1) / TICK_MS;
	localparam int BLINK_MS  = 800;
	localparam int BLINK_TKS = BLINK_MS / TICK_MS;

	localparam logic [2:0] OT_CONTROL = 3'h0;
	localparam logic [2:0] OT_VENT    = 3'h1;
	localparam logic [2:0] OT_EXTING  = 3'h2;
	localparam logic [2:0] OT_ALARMDV = 3'h3;
	localparam logic [2:0] OT_ROUTING = 3'h4;
	localparam logic [2:0] OT_NEUTRAL = 3'h5;
	localparam logic [2:0] OT_ILOCK   = 3'h6;

	localparam logic [2:0] TA_STEADY  = 3'h0;
	localparam logic [2:0] TA_INTER   = 3'h1;
	localparam logic [2:0] TA_PULSE   = 3'h2;
	localparam logic [2:0] TA_DSTEADY = 3'h3;
	localparam logic [2:0] TA_DINTER  = 3'h4;
	localparam logic [2:0] TA_DPULSE  = 3'h5;
	localparam logic [2:0] TA_DEACT   = 3'h6;

	localparam logic [2:0] KD_PNL_VOLT  = 3'h0;
	localparam logic [2:0] KD_PNL_RELAY = 3'h1;
	localparam logic [2:0] KD_RLY_BOARD = 3'h2;
	localparam logic [2:0] KD_EXT_BOARD = 3'h3;
	localparam logic [2:0] KD_ADR_RELAY = 3'h4;
	localparam logic [2:0] KD_ADR_VOLT  = 3'h5;
	localparam logic [2:0] KD_IO_UNIT   = 3'h6;
	localparam logic [2:0] KD_SOUNDER   = 3'h7;

	localparam logic [2:0] OP_END  = 3'h0;
	localparam logic [2:0] OP_TRIG = 3'h1;
	localparam logic [2:0] OP_SEQ  = 3'h2;
	localparam logic [2:0] OP_RST  = 3'h3;
	localparam logic [2:0] OP_NOT  = 3'h4;
	localparam logic [2:0] OP_AND  = 3'h5;
	localparam logic [2:0] OP_OR   = 3'h6;

	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_POL      = 3;
	localparam int CFG_NOSUP    = 4;
	localparam int CFG_KIND_LSB = 5;
	localparam int CFG_PROF_LSB = 8;
	localparam logic [11:0] CFG_RST = 12'h000;

	localparam int PF_DELAY = 0;
	localparam int PF_PULSE = 1;
	localparam int PF_OFF   = 2;
	localparam int PF_DEACT = 3;

	localparam logic [9:0] REG_GRP_DIS = 10'h008;
	localparam logic [9:0] REG_STATUS  = 10'h010;
	localparam logic [9:0] REG_ILOCK   = 10'h011;
	localparam logic [6:0] CFG_PAGE    = 7'h00;
	localparam logic [5:0] SEQ_PAGE    = 6'h02;
	localparam logic [2:0] PROF_PAGE   = 3'h1;

	typedef enum logic [1:0] {
		EV_IDLE = 2'b01,
		EV_RUN  = 2'b10
	} poc_ev_t;

	typedef enum logic [5:0] {
		TS_IDLE = 6'b000001,
		TS_DLY  = 6'b000010,
		TS_ON   = 6'b000100,
		TS_OFF  = 6'b001000,
		TS_DONE = 6'b010000,
		TS_HOLD = 6'b100000
	} poc_ts_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [9:0] addr;
		logic [31:0] wdata;
	} poc_bus_t;

	typedef struct packed {
		logic controls_off_setting;
		logic alarm_devices_off_setting;
		logic fbtx_disabled;
		logic vent_feedback;
		logic ext_feedback;
		logic fbtx_feedback;
	} poc_sys_t;

	typedef struct packed {
		logic vent;
		logic extinguish;
		logic fbtx;
		logic alarm_dev_fault;
		logic fbtx_fault;
	} poc_leds_t;

	typedef struct packed {
		logic                    sil_s1;
		logic                    sil_s2;
		logic [21:0]             div;
		logic                    tick;
		poc_ev_t                 ev;
		logic [2:0]              ev_out;
		logic [5:0]              ev_pc;
		logic [7:0]              ev_stk;
		logic [5:0]              ev_terms;
		logic                    ev_done;
		logic [N_OUT-1:0]        req;
		logic [N_OUT-1:0][11:0]  cfg;
		logic [6:0]              grp_dis;
		logic [N_PROF-1:0][2:0]  pty;
		logic [N_PROF-1:0][3:0][15:0] ptm;
		logic [N_SEQ-1:0][5:0]   sq_lo;
		logic [N_SEQ-1:0][5:0]   sq_hi;
		logic [N_SEQ-1:0][6:0]   sq_qty;
		logic [N_RPC-1:0][5:0]   rp_cnt;
		logic [3:0]              blink_cnt;
		logic                    blink;
		poc_ts_t [N_OUT-1:0]     ts;
		logic [N_OUT-1:0][15:0]  tc;
		logic [N_OUT-1:0]        level;
		logic [N_OUT-1:0]        sup;
		logic [N_OUT-1:0]        ilk;
		poc_leds_t               leds;
		logic [31:0]             rdata;
	} poc_state_t;

endpackage : poc_pkg

// [verification/poc_out_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module poc_out_partner import poc_pkg::*; (
	input  wire logic             mclk,
	input  wire logic [N_OUT-1:0] out_level,
	input  wire logic [N_OUT-1:0] supervise_en,
	input  wire logic [N_OUT-1:0] open_wire,
	output var  logic [N_OUT-1:0] out_fault
);
	// Line current only measured on supervised outputs
	always_ff @(posedge mclk) begin
		out_fault <= supervise_en & open_wire;
	end
endmodule : poc_out_partner
`default_nettype wire

// [verification/poc_output_ctrl_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module poc_output_ctrl_properties import poc_pkg::*; (
	input wire logic             mclk,
	input wire logic             rst,
	input wire poc_bus_t         bus,
	input wire logic [31:0]      rdata,
	input wire poc_sys_t         sys,
	input wire logic [N_OUT-1:0] out_level,
	input wire logic [N_OUT-1:0] supervise_en,
	input wire logic [N_OUT-1:0] interlock_status_view,
	input wire poc_leds_t        leds
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_cfg_wr_rd;
		bus.wr && bus.addr < 10'h008 ##2
		bus.rd && bus.addr == $past(bus.addr, 2);
	endsequence
	sequence s_rd(a);
		bus.rd && bus.addr == a;
	endsequence

	rd_idle_a: assert property (
		!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	cfg_back_a: assert property (
		s_cfg_wr_rd |=> rdata[11:0] == $past(bus.wdata[11:0], 3))
		else $error("config read back differs");
	status_lvl_a: assert property (
		s_rd(REG_STATUS) |=> rdata[23:16] == $past(out_level))
		else $error("status level differs from pins");
	ilk_sup_a: assert property (
		s_rd(REG_ILOCK) |=> rdata[15:0] ==
		{$past(supervise_en), $past(interlock_status_view)})
		else $error("interlock or supervise view differs");
	unmapped_rd_a: assert property (
		s_rd(10'h012) |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	vent_led_a: assert property (
		sys.vent_feedback |-> ##[0:1000]
		(leds.vent || !sys.vent_feedback))
		else $error("vent feedback did not light led");
	ext_led_a: assert property (
		sys.ext_feedback |-> ##[0:1000]
		(leds.extinguish || !sys.ext_feedback))
		else $error("ext feedback did not light led");
	fbtx_led_a: assert property (
		sys.fbtx_feedback |-> ##[0:1000]
		(leds.fbtx || !sys.fbtx_feedback))
		else $error("fbtx feedback did not light led");
	reset_quiet_a: assert property (
		$fell(rst) |-> out_level == '0 && interlock_status_view == '0)
		else $error("outputs active after reset");
endmodule : poc_output_ctrl_properties

bind poc_output_ctrl poc_output_ctrl_properties u_chk (
	.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .sys(sys),
	.out_level(out_level), .supervise_en(supervise_en),
	.interlock_status_view(interlock_status_view), .leds(leds)
);
`default_nettype wire

// [verification/programmable_output_control_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module programmable_output_control_tb_top;
	import poc_pkg::*;
	localparam int TCK = 515;
	localparam logic [8:0] PROG [7] = '{{OP_TRIG, 6'd0},
		{OP_TRIG, 6'd1}, {OP_NOT, 6'd0}, {OP_TRIG, 6'd2},
		{OP_AND, 6'd0}, {OP_OR, 6'd0}, {OP_END, 6'd0}};
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	poc_bus_t         bus = '0;
	poc_sys_t         sys = '0;
	logic             sil = 1'b0;
	logic [63:0]      trig = '0;
	logic [63:0]      apts = '0;
	logic [N_OUT-1:0] opn = '0;
	logic [N_RPC-1:0] rpi = '0;
	logic [31:0]      rdata, q;
	logic [N_OUT-1:0] lvl, sup, ilk, flt;
	poc_leds_t        leds;
	int               fails = 0;
	int               cmp_count = 0;
	integer           seed = 32'h2034895d;
	int               k, i;
	logic [2:0]       t, bits, kind;
	logic             pol, s, on, b, a, s0, s1, ns;
	poc_sys_t         y;
	logic [6:0]       g;

	always #25 mclk = ~mclk;

	poc_output_ctrl #(.TICK_CYCLES(TCK)) u_dut (
		.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .sys(sys),
		.silence_btn(sil), .trig_in(trig), .alarm_pts(apts),
		.rst_pulse_in(rpi), .out_fault(flt), .out_level(lvl),
		.supervise_en(sup), .interlock_status_view(ilk), .leds(leds)
	);
	poc_out_partner u_far (
		.mclk(mclk), .out_level(lvl), .supervise_en(sup),
		.open_wire(opn), .out_fault(flt)
	);

	task automatic xfer(input logic w, input logic [9:0] ad,
		input logic [31:0] d);
		@(posedge mclk);
		bus <= '{w, !w, ad, d};
		@(posedge mclk);
		bus <= '0;
		#1 q = rdata;
	endtask : xfer

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		cmp_count++;
		if (got !== e) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, e);
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n * TCK) @(posedge mclk);
	endtask : ticks

	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	function automatic logic blk(input logic [2:0] ty, input poc_sys_t v,
		input logic [6:0] gd, input logic sl);
		return ty != OT_NEUTRAL && (gd[ty] ||
			(ty <= OT_EXTING && v.controls_off_setting) ||
			(ty == OT_ALARMDV && (v.alarm_devices_off_setting || sl)) ||
			(ty == OT_ROUTING && v.fbtx_disabled));
	endfunction : blk

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		xfer(1'b0, 10'h000, 32'h0);
		chk(q, 32'h0);
		xfer(1'b0, 10'h012, 32'h0);
		chk(q, 32'h0);
		for (i = 0; i < 7; i++) begin
			xfer(1'b1, 10'h200 + 10'(i), 32'(PROG[i]));
		end
		// First eight: neutral type with every disable applied
		for (k = 0; k < 24; k++) begin
			t = k < 8 ? OT_NEUTRAL : 3'($unsigned($random(seed)) % 7);
			pol = k < 8 ? 1'b0 : 1'($random(seed));
			bits = k < 8 ? 3'(k) : 3'($random(seed));
			y = k < 8 ? poc_sys_t'(6'h3F) : poc_sys_t'(6'($random(seed)));
			g = k < 8 ? 7'h7F : 7'($random(seed)) & 7'($random(seed));
			s = k < 8 ? 1'b1 : 1'($random(seed));
			xfer(1'b1, 10'h000, {20'h0, 4'hF, KD_PNL_RELAY, 1'b0, pol, t});
			xfer(1'b1, REG_GRP_DIS, {25'h0, g});
			sys <= y;
			sil <= s;
			trig <= {32'($random(seed)), 29'($random(seed)), bits};
			apts <= {32'($random(seed)), 32'($random(seed))};
			ticks(3);
			on = bits[0] | (!bits[1] & bits[2]);
			b = blk(t, y, g, s);
			a = on & !b;
			chk(lvl[0], pol ^ a);
			chk(leds.vent, y.vent_feedback | (a && t == OT_VENT));
			chk(leds.extinguish, y.ext_feedback | (a && t == OT_EXTING));
			chk(leds.fbtx, y.fbtx_feedback | (a && t == OT_ROUTING));
			chk(ilk[0], a && t == OT_ILOCK);
			if (t == OT_ALARMDV) chk(leds.alarm_dev_fault, b);
			if (t == OT_ROUTING) chk(leds.fbtx_fault, b);
			xfer(1'b0, REG_STATUS, 32'h0);
			chk(q[0], on);
			chk(q[16], pol ^ a);
		end
		xfer(1'b0, REG_GRP_DIS, 32'h0);
		chk(q, {25'h0, g});
		for (k = 0; k < 32; k++) begin
			kind = 3'(k);
			pol = k[3];
			ns = k[4];
			xfer(1'b1, 10'h000, {20'h0, 4'hF, kind, ns, pol, 3'h0});
			ticks(2);
			chk(sup[0], (kind == KD_PNL_VOLT || kind == KD_ADR_VOLT)
				&& !pol && !ns);
			xfer(1'b0, REG_ILOCK, 32'h0);
		end
		xfer(1'b1, 10'h000, {20'h0, 4'hF, KD_PNL_VOLT, 2'b00, OT_ALARMDV});
		xfer(1'b1, REG_GRP_DIS, 32'h0);
		sys <= '0;
		sil <= 1'b0;
		opn <= 8'h01;
		ticks(2);
		s0 = 1'b0;
		s1 = 1'b0;
		repeat (20 * TCK) begin
			@(posedge mclk);
			s0 = s0 | (leds.alarm_dev_fault === 1'b0);
			s1 = s1 | (leds.alarm_dev_fault === 1'b1);
		end
		chk({s0, s1}, 2'b11);
		opn <= '0;
		// Reset-pulse term on output 1, panel relay then addressable voltage
		xfer(1'b1, 10'h240, {23'h0, OP_RST, 6'd0});
		xfer(1'b1, 10'h241, {23'h0, OP_END, 6'd0});
		xfer(1'b1, 10'h001, {20'h0, 4'hF, KD_PNL_RELAY, 2'b00, OT_NEUTRAL});
		@(posedge mclk);
		rpi <= 4'h1;
		@(posedge mclk);
		rpi <= 4'h0;
		ticks(2);
		chk(lvl[1], 1'b1);
		xfer(1'b1, 10'h001, {20'h0, 4'hF, KD_ADR_VOLT, 2'b00, OT_NEUTRAL});
		ticks(2);
		chk(lvl[1], 1'b0);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		xfer(1'b0, 10'h000, 32'h0);
		chk(q, 32'h0);
		chk(lvl, 8'h00);
		final_report();
	end
endmodule : programmable_output_control_tb_top
`default_nettype wire

// [verilog/poc_output_ctrl.sv]
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module poc_output_ctrl import poc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire poc_bus_t          bus,
	output var  logic [31:0]       rdata,
	input  wire poc_sys_t          sys,
	input  wire logic              silence_btn,
	input  wire logic [63:0]       trig_in,
	input  wire logic [63:0]       alarm_pts,
	input  wire logic [N_RPC-1:0]  rst_pulse_in,
	input  wire logic [N_OUT-1:0]  out_fault,
	output var  logic [N_OUT-1:0]  out_level,
	output var  logic [N_OUT-1:0]  supervise_en,
	output var  logic [N_OUT-1:0]  interlock_status_view,
	output var  poc_leds_t         leds
);

	poc_state_t s;
	poc_state_t n;
	logic [8:0] prog [0:511];
	logic [8:0] pword;

	logic [N_OUT-1:0] blocked;
	logic [N_OUT-1:0] act;
	logic [N_OUT-1:0] timed_on;
	logic [N_OUT-1:0] force_eq;
	logic [N_OUT-1:0][2:0] ety;
	logic [N_OUT-1:0][3:0] pidx;
	logic [N_OUT-1:0][2:0] otype;
	logic [N_OUT-1:0][2:0] okind;

	function automatic logic [6:0] count_range(input logic [63:0] pts,
			input logic [5:0] lo, input logic [5:0] hi);
		logic [6:0] c;
		c = 7'h00;
		for (int k = 0; k < 64; k++) begin
			if (6'(k) >= lo && 6'(k) <= hi && pts[k])
				c = c + 7'h01;
		end
		return c;
	endfunction : count_range

	function automatic logic is_blocked(input logic [2:0] t,
			input logic [6:0] grp, input poc_sys_t y, input logic sil);
		logic b;
		b = 1'b0;
		case (t)
			OT_CONTROL, OT_VENT, OT_EXTING:
				b = grp[t] | y.controls_off_setting;
			OT_ALARMDV:
				b = grp[t] | y.alarm_devices_off_setting | sil;
			OT_ROUTING:
				b = grp[t] | y.fbtx_disabled;
			OT_NEUTRAL:
				b = 1'b0;
			OT_ILOCK:
				b = grp[t];
			default:
				b = 1'b0;
		endcase
		return b;
	endfunction : is_blocked

	function automatic logic [2:0] permit(input logic [2:0] t,
			input logic [2:0] k, input logic [2:0] ty);
		logic [2:0] r;
		r = ty;
		if (ty > TA_DEACT)
			r = TA_STEADY;
		if ((ty == TA_PULSE || ty == TA_DPULSE) && k != KD_PNL_VOLT &&
				k != KD_PNL_RELAY)
			r = TA_STEADY;
		if ((ty == TA_INTER || ty == TA_DINTER) && k != KD_PNL_VOLT &&
				k != KD_PNL_RELAY && k != KD_ADR_VOLT)
			r = TA_STEADY;
		if (t == OT_ILOCK && ty != TA_STEADY && ty != TA_DSTEADY)
			r = TA_STEADY;
		if (k == KD_EXT_BOARD)
			r = TA_STEADY;
		return r;
	endfunction : permit

	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_out
			logic [2:0] raw;
			assign otype[g] = s.cfg[g][CFG_TYPE_LSB +: 3];
			assign okind[g] = s.cfg[g][CFG_KIND_LSB +: 3];
			assign pidx[g] = s.cfg[g][CFG_PROF_LSB +: 4];
			assign raw = (pidx[g] < 4'(N_PROF)) ? s.pty[pidx[g]] : TA_STEADY;
			assign ety[g] = permit(otype[g], okind[g], raw);
			assign blocked[g] = is_blocked(otype[g], s.grp_dis, sys,
				s.sil_s2);
			assign act[g] = s.req[g] & ~blocked[g];
			assign timed_on[g] = (s.ts[g] == TS_ON) || (s.ts[g] == TS_HOLD);
			assign force_eq[g] = okind[g] == KD_ADR_VOLT;
		end
	endgenerate

	assign pword = prog[{s.ev_out, s.ev_pc}];

	always_ff @(posedge mclk) begin
		if (bus.wr && bus.addr[9])
			prog[bus.addr[8:0]] <= bus.wdata[8:0];
	end

	always_comb begin
		logic fin;
		logic v;
		logic [3:0] p;
		logic [15:0] t_dly;
		logic [15:0] t_pul;
		logic [15:0] t_off;
		logic [15:0] t_dea;
		logic any_ad_dis;
		logic any_ad_flt;
		logic any_fb_dis;
		logic any_fb_flt;
		fin = 1'b0;
		v = 1'b0;
		p = 4'h0;
		t_dly = 16'h0000;
		t_pul = 16'h0000;
		t_off = 16'h0000;
		t_dea = 16'h0000;
		any_ad_dis = 1'b0;
		any_ad_flt = 1'b0;
		any_fb_dis = 1'b0;
		any_fb_flt = 1'b0;
		n = s;
		n.sil_s1 = silence_btn;
		n.sil_s2 = s.sil_s1;
		n.ev_done = 1'b0;
		n.rdata = 32'h0000_0000;

		// System tick divider
		n.tick = 1'b0;
		if (s.div == 22'(TICK_CYCLES - 1)) begin
			n.div = 22'h000000;
			n.tick = 1'b1;
		end else begin
			n.div = s.div + 22'h000001;
		end

		// Blink source, equal on and off periods
		if (s.tick) begin
			if (s.blink_cnt >= 4'(BLINK_TKS - 1)) begin
				n.blink_cnt = 4'h0;
				n.blink = ~s.blink;
			end else begin
				n.blink_cnt = s.blink_cnt + 4'h1;
			end
		end

		// Reset-pulse windows, a new pulse wins over the count
		for (int r = 0; r < N_RPC; r++) begin
			if (rst_pulse_in[r])
				n.rp_cnt[r] = 6'(RP_TICKS);
			else if (s.tick && s.rp_cnt[r] != 6'h00)
				n.rp_cnt[r] = s.rp_cnt[r] - 6'h01;
		end

		// Postfix expression walker
		case (s.ev)
			EV_IDLE: begin
				if (s.tick) begin
					n.ev = EV_RUN;
					n.ev_out = 3'h0;
					n.ev_pc = 6'h00;
					n.ev_stk = 8'h00;
					n.ev_terms = 6'h00;
				end
			end
			EV_RUN: begin
				n.ev_pc = s.ev_pc + 6'h01;
				case (pword[8:6])
					OP_TRIG, OP_SEQ, OP_RST: begin
						if (s.ev_terms == 6'(MAX_TERMS)) begin
							fin = 1'b1;
						end else begin
							if (pword[8:6] == OP_TRIG)
								v = trig_in[pword[5:0]];
							else if (pword[8:6] == OP_SEQ)
								v = count_range(alarm_pts,
									s.sq_lo[pword[1:0]],
									s.sq_hi[pword[1:0]]) >=
									s.sq_qty[pword[1:0]];
							else
								v = (s.rp_cnt[pword[1:0]] != 6'h00) &&
									(okind[s.ev_out] == KD_PNL_VOLT ||
									okind[s.ev_out] == KD_PNL_RELAY ||
									okind[s.ev_out] == KD_ADR_RELAY ||
									okind[s.ev_out] == KD_IO_UNIT);
							n.ev_stk = {s.ev_stk[6:0], v};
							n.ev_terms = s.ev_terms + 6'h01;
						end
					end
					OP_NOT:
						n.ev_stk[0] = ~s.ev_stk[0];
					OP_AND:
						n.ev_stk = {1'b0, s.ev_stk[7:2],
							s.ev_stk[1] & s.ev_stk[0]};
					OP_OR:
						n.ev_stk = {1'b0, s.ev_stk[7:2],
							s.ev_stk[1] | s.ev_stk[0]};
					default:
						fin = 1'b1;
				endcase
				if (s.ev_pc == 6'h3F)
					fin = 1'b1;
				if (fin) begin
					n.req[s.ev_out] = (pword[8:6] == OP_END ||
						s.ev_terms == 6'(MAX_TERMS)) ? s.ev_stk[0] :
						n.ev_stk[0];
					n.ev_pc = 6'h00;
					n.ev_stk = 8'h00;
					n.ev_terms = 6'h00;
					if (s.ev_out == 3'(N_OUT - 1)) begin
						n.ev = EV_IDLE;
						n.ev_done = 1'b1;
					end else begin
						n.ev_out = s.ev_out + 3'h1;
					end
				end
			end
			default:
				n.ev = EV_IDLE;
		endcase

		// Activation timing, once per completed evaluation
		for (int i = 0; i < N_OUT; i++) begin
			p = (pidx[i] < 4'(N_PROF)) ? pidx[i] : 4'h0;
			t_dly = s.ptm[p][PF_DELAY];
			t_pul = force_eq[i] ? 16'(BLINK_TKS) : s.ptm[p][PF_PULSE];
			t_off = force_eq[i] ? 16'(BLINK_TKS) : s.ptm[p][PF_OFF];
			t_dea = s.ptm[p][PF_DEACT];
			if (s.ev_done) begin
				case (s.ts[i])
					TS_IDLE: begin
						if (act[i]) begin
							if (ety[i] == TA_DSTEADY || ety[i] == TA_DINTER ||
									ety[i] == TA_DPULSE) begin
								n.ts[i] = TS_DLY;
								n.tc[i] = t_dly;
							end else begin
								n.ts[i] = TS_ON;
								n.tc[i] = t_pul;
							end
						end
					end
					TS_DLY: begin
						if (!act[i])
							n.ts[i] = TS_IDLE;
						else if (s.tc[i] <= 16'h0001) begin
							n.ts[i] = TS_ON;
							n.tc[i] = t_pul;
						end else
							n.tc[i] = s.tc[i] - 16'h0001;
					end
					TS_ON: begin
						if (!act[i]) begin
							if (ety[i] == TA_DEACT && !blocked[i]) begin
								n.ts[i] = TS_HOLD;
								n.tc[i] = t_dea;
							end else
								n.ts[i] = TS_IDLE;
						end else if (ety[i] == TA_INTER ||
								ety[i] == TA_DINTER) begin
							if (s.tc[i] <= 16'h0001) begin
								n.ts[i] = TS_OFF;
								n.tc[i] = t_off;
							end else
								n.tc[i] = s.tc[i] - 16'h0001;
						end else if (ety[i] == TA_PULSE ||
								ety[i] == TA_DPULSE) begin
							if (s.tc[i] <= 16'h0001)
								n.ts[i] = TS_DONE;
							else
								n.tc[i] = s.tc[i] - 16'h0001;
						end
					end
					TS_OFF: begin
						if (!act[i])
							n.ts[i] = TS_IDLE;
						else if (s.tc[i] <= 16'h0001) begin
							n.ts[i] = TS_ON;
							n.tc[i] = t_pul;
						end else
							n.tc[i] = s.tc[i] - 16'h0001;
					end
					TS_DONE: begin
						if (!act[i])
							n.ts[i] = TS_IDLE;
					end
					TS_HOLD: begin
						if (act[i])
							n.ts[i] = TS_ON;
						else if (blocked[i] || s.tc[i] <= 16'h0001)
							n.ts[i] = TS_IDLE;
						else
							n.tc[i] = s.tc[i] - 16'h0001;
					end
					default:
						n.ts[i] = TS_IDLE;
				endcase
			end
		end

		// Pin stage, indicators and supervision
		n.leds = '0;
		for (int i = 0; i < N_OUT; i++) begin
			n.level[i] = s.cfg[i][CFG_POL] ^
				(timed_on[i] & ~blocked[i]);
			n.sup[i] = (okind[i] == KD_PNL_VOLT ||
				okind[i] == KD_ADR_VOLT) &&
				!s.cfg[i][CFG_NOSUP] &&
				!s.cfg[i][CFG_POL];
			n.ilk[i] = (otype[i] == OT_ILOCK) && timed_on[i] &&
				!blocked[i];
			if (timed_on[i] && !blocked[i]) begin
				if (otype[i] == OT_VENT)
					n.leds.vent = 1'b1;
				if (otype[i] == OT_EXTING)
					n.leds.extinguish = 1'b1;
				if (otype[i] == OT_ROUTING)
					n.leds.fbtx = 1'b1;
			end
			if (otype[i] == OT_ALARMDV) begin
				any_ad_dis = any_ad_dis | blocked[i];
				any_ad_flt = any_ad_flt | out_fault[i];
			end
			if (otype[i] == OT_ROUTING) begin
				any_fb_dis = any_fb_dis | blocked[i];
				any_fb_flt = any_fb_flt | out_fault[i];
			end
		end
		n.leds.vent = n.leds.vent | sys.vent_feedback;
		n.leds.extinguish = n.leds.extinguish | sys.ext_feedback;
		n.leds.fbtx = n.leds.fbtx | sys.fbtx_feedback;
		n.leds.alarm_dev_fault = any_ad_dis |
			(any_ad_flt & s.blink);
		n.leds.fbtx_fault = any_fb_dis | (any_fb_flt & s.blink);

		// Register writes
		if (bus.wr) begin
			if (bus.addr[9:3] == CFG_PAGE)
				n.cfg[bus.addr[2:0]] = bus.wdata[11:0];
			else if (bus.addr == REG_GRP_DIS)
				n.grp_dis = bus.wdata[6:0];
			else if (bus.addr[9:4] == SEQ_PAGE) begin
				case (bus.addr[1:0])
					2'h0: n.sq_lo[bus.addr[3:2]] = bus.wdata[5:0];
					2'h1: n.sq_hi[bus.addr[3:2]] = bus.wdata[5:0];
					2'h2: n.sq_qty[bus.addr[3:2]] = bus.wdata[6:0];
					default: ;
				endcase
			end else if (bus.addr[9:7] == PROF_PAGE &&
					bus.addr[6:3] < 4'(N_PROF)) begin
				if (bus.addr[2:0] == 3'h0)
					n.pty[bus.addr[6:3]] = bus.wdata[2:0];
				else if (bus.addr[2:0] <= 3'h4)
					n.ptm[bus.addr[6:3]][2'(bus.addr[2:0] - 3'h1)] =
						bus.wdata[15:0];
			end
		end

		// Register reads, answered in the next cycle
		if (bus.rd) begin
			if (bus.addr[9])
				n.rdata = {23'h000000, prog[bus.addr[8:0]]};
			else if (bus.addr[9:3] == CFG_PAGE)
				n.rdata = {20'h00000, s.cfg[bus.addr[2:0]]};
			else if (bus.addr == REG_GRP_DIS)
				n.rdata = {25'h0000000, s.grp_dis};
			else if (bus.addr == REG_STATUS)
				n.rdata = {8'h00, s.level, timed_on, s.req};
			else if (bus.addr == REG_ILOCK)
				n.rdata = {16'h0000, s.sup, s.ilk};
			else if (bus.addr[9:4] == SEQ_PAGE) begin
				case (bus.addr[1:0])
					2'h0: n.rdata = {26'h0, s.sq_lo[bus.addr[3:2]]};
					2'h1: n.rdata = {26'h0, s.sq_hi[bus.addr[3:2]]};
					2'h2: n.rdata = {25'h0, s.sq_qty[bus.addr[3:2]]};
					default: n.rdata = 32'h0000_0000;
				endcase
			end else if (bus.addr[9:7] == PROF_PAGE &&
					bus.addr[6:3] < 4'(N_PROF)) begin
				if (bus.addr[2:0] == 3'h0)
					n.rdata = {29'h0, s.pty[bus.addr[6:3]]};
				else if (bus.addr[2:0] <= 3'h4)
					n.rdata = {16'h0000, s.ptm[bus.addr[6:3]]
						[2'(bus.addr[2:0] - 3'h1)]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
			s.ev <= EV_IDLE;
			for (int i = 0; i < N_OUT; i++) begin
				s.ts[i] <= TS_IDLE;
				s.cfg[i] <= CFG_RST;
			end
		end else begin
			s <= n;
		end
	end

	assign rdata = s.rdata;
	assign out_level = s.level;
	assign supervise_en = s.sup;
	assign interlock_status_view = s.ilk;
	assign leds = s.leds;

endmodule : poc_output_ctrl

`default_nettype wire
